// file: src/i2csar_pkg.sv
/*
  Holds the register map, field positions, reset values and widths of the
  status, enable, FIFO-level, data-hold and transmit-abort-cause block.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package i2csar_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] I2CSAR_OFS_CLR_ALL = 8'h40;
  localparam logic [7:0] I2CSAR_OFS_CLR_ABRT = 8'h54;
  localparam logic [7:0] I2CSAR_OFS_CLR_GCALL = 8'h68;
  localparam logic [7:0] I2CSAR_OFS_ENABLE = 8'h6C;
  localparam logic [7:0] I2CSAR_OFS_STATUS = 8'h70;
  localparam logic [7:0] I2CSAR_OFS_TXLVL = 8'h74;
  localparam logic [7:0] I2CSAR_OFS_RXLVL = 8'h78;
  localparam logic [7:0] I2CSAR_OFS_HOLD = 8'h7C;
  localparam logic [7:0] I2CSAR_OFS_ABRT = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int I2CSAR_EN_ON = 0;
  localparam int I2CSAR_EN_ABORT = 1;
  localparam int I2CSAR_ST_ACT = 0;
  localparam int I2CSAR_ST_TX_FIFO_HAS_ROOM = 1;
  localparam int I2CSAR_ST_TFE = 2;
  localparam int I2CSAR_ST_RX_FIFO_NONEMPTY = 3;
  localparam int I2CSAR_ST_RFF = 4;
  localparam int I2CSAR_ST_MST = 5;
  localparam int I2CSAR_ST_SLV = 6;
  localparam int I2CSAR_AB_SW = 16;
  localparam int I2CSAR_AB_SLVRD = 15;
  localparam int I2CSAR_AB_SLVLOST = 14;
  localparam int I2CSAR_AB_STALE = 13;
  localparam int I2CSAR_AB_ARB = 12;
  localparam int I2CSAR_AB_MDIS = 11;
  localparam int I2CSAR_AB_LRD = 10;
  localparam int I2CSAR_AB_SBNR = 9;
  localparam int I2CSAR_AB_HSNR = 8;
  localparam int I2CSAR_AB_SBACK = 7;
  localparam int I2CSAR_AB_HSACK = 6;
  localparam int I2CSAR_AB_GCRD = 5;
  localparam int I2CSAR_AB_GCNAK = 4;
  localparam int I2CSAR_AB_DNAK = 3;
  localparam int I2CSAR_AB_LA2NAK = 2;
  localparam int I2CSAR_AB_LA1NAK = 1;
  localparam int I2CSAR_AB_A7NAK = 0;
  localparam int I2CSAR_AB_FLUSH_LSB = 24;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int I2CSAR_CAUSE_W = 17;
  localparam int I2CSAR_LVL_W = 4;
  localparam int I2CSAR_FLUSH_W = 8;
  localparam int I2CSAR_HOLD_W = 16;
  localparam logic [6:0] I2CSAR_STATUS_RST = 7'h06;
  localparam logic [15:0] I2CSAR_HOLD_RST = 16'h0001;
  localparam logic [15:0] I2CSAR_HOLD_ONE = 16'h0001;
  localparam logic [31:0] I2CSAR_ZERO = 32'h0000_0000;

endpackage

// file: src/i2csar_regs.sv
/*
  Status, enable, FIFO-level, data-hold and transmit-abort-cause registers of
  a two-wire serial controller, with the data-hold timer on the clock line.
  Assumes the master/slave state machines and FIFOs sit on pclk and give
  one-cycle event pulses; the clock line arrives from a pin and is synchronised.
*/
// Register access over APB was chosen for this implementation.
// How it works
// - Reading general-call clear register clears that flag.
// - Enable bit 0 switches controller on or off.
// - Enable bit 1 starts abort, reads busy.
// - Status bits 6,5 show slave/master machines active.
// - Status bits 4,3 show receive full/nonempty.
// - Status bits 2,1 show transmit empty/room.
// - Level registers report both FIFO entry counts.
// - Hold count delays data after clock edges.
// - Abort register keeps transmit level before abort.
// - Software abort in master mode sets bit 16.
// - Slave read with read command sets bit 15.
// - Slave losing bus while sending sets bit 14.
// - Read request with stale data sets bit 13.
// - Arbitration loss sets bit 12 too.
// - Master start while master disabled sets bit 11.
// - No repeated start blocks three kinds, bits 10..8.
// - Acked start byte or code sets bits 7,6.
// - Read after general call sets bit 5.
// - Unacknowledged general call sets bit 4.
// - Slave must ack data; nack sets bit 3.
// - Unacknowledged second long-address byte sets bit 2.
// - Combined or abort clear reads wipe causes.
`timescale 1ns/1ns

module i2csar_regs
  import i2csar_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller state.
  input wire logic master_fsm_busy,
  input wire logic slave_fsm_busy,
  input wire logic bus_other_busy,
  input wire logic [3:0] tx_fifo_count,
  input wire logic [3:0] rx_fifo_count,
  input wire logic abort_done,
  input wire logic master_mode,
  input wire logic repeated_start_allow,
  // Abort events from the state machines, one-cycle pulses.
  input wire logic slave_read_active,
  input wire logic data_command_write,
  input wire logic [9:8] data_command_bits,
  input wire logic slave_bus_lost,
  input wire logic slave_read_request,
  input wire logic master_arbitration_lost_flag,
  input wire logic master_start_req,
  input wire logic long_addr_read_req,
  input wire logic start_byte_req,
  input wire logic high_speed_req,
  input wire logic start_byte_acked,
  input wire logic high_speed_code_acked,
  input wire logic general_call_sent,
  input wire logic general_call_unacked,
  input wire logic data_byte_unacked,
  input wire logic long_addr_second_unacked,
  input wire logic long_addr_first_unacked,
  input wire logic short_addr_unacked,
  // Clock line as seen on the pin.
  input wire logic scl_line,
  // Controls and events towards the controller.
  output logic controller_enable,
  output logic abort_request,
  output logic general_call_clear_bit,
  output logic transmit_abort_clear,
  output logic transmit_abort_irq,
  output logic [15:0] data_hold_count,
  output logic data_hold_done
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 15) begin : g_bad_depth
    $error("FIFO_DEPTH must lie between 1 and 15");
  end

  localparam logic [3:0] DEPTH = 4'(FIFO_DEPTH);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic rd_acc;
  logic wr_acc;
  logic mapped;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic en_q;
  logic abort_q;
  logic [6:0] status_q;
  logic [3:0] txlvl_q;
  logic [3:0] rxlvl_q;
  logic [15:0] hold_q;
  logic [16:0] cause_q;
  logic [16:0] cause_set;
  logic [7:0] flush_q;
  logic clr_cause;

  // Single access cycle; read data is captured during setup.
  assign setup_ph = psel & ~penable;
  assign rd_acc = psel & penable & ~pwrite;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;

  // Address decode and read mux; unmapped addresses error, reserved bits zero.
  always_comb begin
    mapped = 1'b1;
    rdata_d = I2CSAR_ZERO;
    unique case (paddr)
      I2CSAR_OFS_CLR_ALL, I2CSAR_OFS_CLR_ABRT, I2CSAR_OFS_CLR_GCALL: begin
        rdata_d = I2CSAR_ZERO;
      end
      I2CSAR_OFS_ENABLE: begin
        rdata_d[I2CSAR_EN_ON] = en_q;
        rdata_d[I2CSAR_EN_ABORT] = abort_q;
      end
      I2CSAR_OFS_STATUS: begin
        rdata_d[6:0] = status_q;
      end
      I2CSAR_OFS_TXLVL: begin
        rdata_d[I2CSAR_LVL_W-1:0] = txlvl_q;
      end
      I2CSAR_OFS_RXLVL: begin
        rdata_d[I2CSAR_LVL_W-1:0] = rxlvl_q;
      end
      I2CSAR_OFS_HOLD: begin
        rdata_d[I2CSAR_HOLD_W-1:0] = hold_q;
      end
      I2CSAR_OFS_ABRT: begin
        rdata_d[I2CSAR_CAUSE_W-1:0] = cause_q;
        rdata_d[31:I2CSAR_AB_FLUSH_LSB] = flush_q;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Read data register, loaded in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= I2CSAR_ZERO;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? I2CSAR_ZERO : rdata_d;
    end
  end

  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // Clear-on-read side effects
  // ----------------------------------------------------------------
  assign general_call_clear_bit = rd_acc & (paddr == I2CSAR_OFS_CLR_GCALL);
  assign clr_cause = rd_acc & ((paddr == I2CSAR_OFS_CLR_ALL) | (paddr == I2CSAR_OFS_CLR_ABRT));
  assign transmit_abort_clear = clr_cause;

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  // Bit 0 turns the controller on and off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else if (wr_acc && paddr == I2CSAR_OFS_ENABLE) begin
      en_q <= pwdata[I2CSAR_EN_ON];
    end
  end

  // Abort bit: a written one sets it, completion clears it, a new set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_q <= 1'b0;
    end else if (wr_acc && paddr == I2CSAR_OFS_ENABLE && pwdata[I2CSAR_EN_ABORT]) begin
      abort_q <= 1'b1;
    end else if (abort_done) begin
      abort_q <= 1'b0;
    end
  end

  assign controller_enable = en_q;
  assign abort_request = abort_q;

  // ----------------------------------------------------------------
  // Status and level registers
  // ----------------------------------------------------------------
  // Sampled copies of machine activity and FIFO state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= I2CSAR_STATUS_RST;
      txlvl_q <= 4'h0;
      rxlvl_q <= 4'h0;
    end else begin
      status_q[I2CSAR_ST_SLV] <= slave_fsm_busy;
      status_q[I2CSAR_ST_MST] <= master_fsm_busy;
      status_q[I2CSAR_ST_RFF] <= (rx_fifo_count == DEPTH);
      status_q[I2CSAR_ST_RX_FIFO_NONEMPTY] <= (rx_fifo_count != 4'h0);
      status_q[I2CSAR_ST_TFE] <= (tx_fifo_count == 4'h0);
      status_q[I2CSAR_ST_TX_FIFO_HAS_ROOM] <= (tx_fifo_count != DEPTH);
      status_q[I2CSAR_ST_ACT] <= master_fsm_busy | slave_fsm_busy | bus_other_busy | abort_q;
      txlvl_q <= tx_fifo_count;
      rxlvl_q <= rx_fifo_count;
    end
  end

  // ----------------------------------------------------------------
  // Data hold register and timer
  // ----------------------------------------------------------------
  logic scl_s1_q;
  logic scl_s2_q;
  logic scl_s3_q;
  logic scl_edge;
  logic [15:0] hold_cnt_q;
  logic hold_done_q;

  // Hold time in core clock periods.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= I2CSAR_HOLD_RST;
    end else if (wr_acc && paddr == I2CSAR_OFS_HOLD) begin
      hold_q <= pwdata[I2CSAR_HOLD_W-1:0];
    end
  end

  assign data_hold_count = hold_q;

  // Two-flop synchroniser for the clock line, then an edge detector.
  // Reset to the idle-high level so that release gives no false edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_line;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
    end
  end

  assign scl_edge = scl_s2_q ^ scl_s3_q;

  // Counts the hold after each edge while the controller is enabled; a zero setting acts as one period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= 16'h0000;
      hold_done_q <= 1'b0;
    end else begin
      hold_done_q <= 1'b0;
      if (scl_edge && en_q) begin
        hold_cnt_q <= (hold_q == 16'h0000) ? I2CSAR_HOLD_ONE : hold_q;
      end else if (hold_cnt_q != 16'h0000) begin
        hold_cnt_q <= hold_cnt_q - I2CSAR_HOLD_ONE;
        hold_done_q <= (hold_cnt_q == I2CSAR_HOLD_ONE);
      end
    end
  end

  assign data_hold_done = hold_done_q;

  // ----------------------------------------------------------------
  // Transmit abort causes
  // ----------------------------------------------------------------
  // Cause detection from the state machine events.
  always_comb begin
    cause_set = 17'h00000;
    cause_set[I2CSAR_AB_SW] = abort_done & master_mode;
    cause_set[I2CSAR_AB_SLVRD] = slave_read_active & data_command_write & data_command_bits[8];
    cause_set[I2CSAR_AB_SLVLOST] = slave_bus_lost;
    cause_set[I2CSAR_AB_STALE] = slave_read_request & (tx_fifo_count != 4'h0);
    cause_set[I2CSAR_AB_ARB] = master_arbitration_lost_flag | slave_bus_lost;
    cause_set[I2CSAR_AB_MDIS] = master_start_req & ~master_mode;
    cause_set[I2CSAR_AB_LRD] = long_addr_read_req & ~repeated_start_allow;
    cause_set[I2CSAR_AB_SBNR] = start_byte_req & ~repeated_start_allow;
    cause_set[I2CSAR_AB_HSNR] = high_speed_req & ~repeated_start_allow;
    cause_set[I2CSAR_AB_SBACK] = start_byte_acked;
    cause_set[I2CSAR_AB_HSACK] = high_speed_code_acked;
    cause_set[I2CSAR_AB_GCRD] = general_call_sent & data_command_bits[9];
    cause_set[I2CSAR_AB_GCNAK] = general_call_unacked;
    cause_set[I2CSAR_AB_DNAK] = data_byte_unacked;
    cause_set[I2CSAR_AB_LA2NAK] = long_addr_second_unacked;
    cause_set[I2CSAR_AB_LA1NAK] = long_addr_first_unacked;
    cause_set[I2CSAR_AB_A7NAK] = short_addr_unacked;
  end

  // Sticky causes; a new event in the clearing cycle is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= 17'h00000;
    end else begin
      cause_q <= (clr_cause ? 17'h00000 : cause_q) | cause_set;
    end
  end

  // Level before the abort event, so software knows what was flushed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_q <= 8'h00;
    end else if (|cause_set) begin
      flush_q <= {4'h0, txlvl_q};
    end else if (clr_cause) begin
      flush_q <= 8'h00;
    end
  end

  // Abort interrupt event towards the raw interrupt status.
  assign transmit_abort_irq = |cause_set;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence hold_edge_s;
    scl_edge && en_q && hold_q == 16'h0003;
  endsequence

  sequence hold_wait_s;
    !data_hold_done ##1 data_hold_done;
  endsequence

  hold_after_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_edge_s ##1 !scl_edge [*3] |-> hold_wait_s)
    else $error("data hold pulse not at end of hold after edge");

  gcall_clear_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    general_call_clear_bit |-> psel && penable && !pwrite && prdata == 32'h0)
    else $error("general call clear without zero read");

  enable_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == I2CSAR_OFS_ENABLE |=> controller_enable == $past(pwdata[0]))
    else $error("enable bit did not follow write");

  abort_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    abort_done && !wr_acc |=> !abort_request)
    else $error("abort bit stayed after done");

  master_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    master_fsm_busy [*2] |-> status_q[I2CSAR_ST_MST] && status_q[I2CSAR_ST_ACT])
    else $error("master activity not shown");

  rx_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_fifo_count == DEPTH |=> status_q[I2CSAR_ST_RFF] && status_q[I2CSAR_ST_RX_FIFO_NONEMPTY])
    else $error("receive full not shown");

  tx_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_fifo_count == 4'h0 |=> status_q[I2CSAR_ST_TFE] && status_q[I2CSAR_ST_TX_FIFO_HAS_ROOM])
    else $error("transmit empty not shown");

  flush_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    transmit_abort_irq |=> flush_q == {4'h0, $past(txlvl_q)})
    else $error("flush count not captured");

  stale_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    slave_read_request && tx_fifo_count != 4'h0 |-> transmit_abort_irq ##1 cause_q[I2CSAR_AB_STALE])
    else $error("stale data abort missing");

  cause_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    cause_q[I2CSAR_AB_DNAK] && !clr_cause |=> cause_q[I2CSAR_AB_DNAK])
    else $error("abort cause dropped without clear");

  cause_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_cause && !transmit_abort_irq |=> cause_q == 17'h0 && flush_q == 8'h0)
    else $error("abort causes not cleared");

endmodule

// file: verification/i2csar_link_partner.sv
/*
  Far side of the two-wire link: makes the clock line in frames and stands
  for the remote slave that acknowledges data bytes.
  Assumes the bench raises frame_go to start a frame and nack_req to refuse.
*/
`timescale 1ns/1ns

module i2csar_link_partner (
  // Commands from the bench.
  input wire logic frame_go,
  input wire logic nack_req,
  // Link side.
  output logic scl_line,
  output logic data_byte_unacked
);
  // The line idles high by its pull-up and only toggles inside a frame.
  // A frame always ends on a full period, so the line is back high after it.
  initial begin
    scl_line = 1'b1;
    #7;
    forever begin
      #40;
      if (frame_go || !scl_line) begin
        scl_line = ~scl_line;
      end
    end
  end

  // The remote slave acknowledges every data byte unless told to refuse.
  assign data_byte_unacked = nack_req;
endmodule

// file: verification/i2csar_regs_tb_top.sv
/*
  Self-checking bench of the status and abort-cause register block.
  Assumes the APB slave answers with no wait states and the partner model
  drives the clock line and the data-nack event.
*/
`timescale 1ns/1ns

module i2csar_regs_tb_top;
  import i2csar_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, err_q, gc_q, tc_q;
  logic master_fsm_busy = 1'b0, slave_fsm_busy = 1'b0, bus_other_busy = 1'b0;
  logic [3:0] tx_fifo_count = 4'h0, rx_fifo_count = 4'h0;
  logic master_mode = 1'b1, repeated_start_allow = 1'b0, slave_read_active = 1'b1;
  logic [9:8] cmd_bits = 2'h3;
  logic [16:0] ev = 17'h0;
  logic frame_go = 1'b0, scl_line, nack_line;
  logic controller_enable, abort_request, general_call_clear_bit, transmit_abort_clear;
  logic transmit_abort_irq, data_hold_done;
  logic [15:0] data_hold_count;
  int fail_count = 0, samples_checked = 0, cyc = 0, edges = 0, pulses = 0, seed, m_cause;
  logic [31:0] v;

  // Core clock, 4 ns period.
  always #2 pclk = ~pclk;

  i2csar_regs i2csar_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_fsm_busy(master_fsm_busy), .slave_fsm_busy(slave_fsm_busy),
    .bus_other_busy(bus_other_busy), .tx_fifo_count(tx_fifo_count), .rx_fifo_count(rx_fifo_count),
    .abort_done(ev[16]), .master_mode(master_mode), .repeated_start_allow(repeated_start_allow),
    .slave_read_active(slave_read_active), .data_command_write(ev[15]), .data_command_bits(cmd_bits),
    .slave_bus_lost(ev[14]), .slave_read_request(ev[13]), .master_arbitration_lost_flag(ev[12]),
    .master_start_req(ev[11]), .long_addr_read_req(ev[10]), .start_byte_req(ev[9]),
    .high_speed_req(ev[8]), .start_byte_acked(ev[7]), .high_speed_code_acked(ev[6]),
    .general_call_sent(ev[5]), .general_call_unacked(ev[4]), .data_byte_unacked(nack_line),
    .long_addr_second_unacked(ev[2]), .long_addr_first_unacked(ev[1]), .short_addr_unacked(ev[0]),
    .scl_line(scl_line), .controller_enable(controller_enable), .abort_request(abort_request),
    .general_call_clear_bit(general_call_clear_bit), .transmit_abort_clear(transmit_abort_clear),
    .transmit_abort_irq(transmit_abort_irq), .data_hold_count(data_hold_count),
    .data_hold_done(data_hold_done));

  i2csar_link_partner i2csar_link_partner_i (.frame_go(frame_go), .nack_req(ev[3]),
    .scl_line(scl_line), .data_byte_unacked(nack_line));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; read data and strobes are taken at the pready edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    gc_q = general_call_clear_bit;
    tc_q = transmit_abort_clear;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(a, 1'b0, 32'h0);
    check(nm, rd_q, exp);
  endtask

  // Expected status word from the levels the bench presents.
  function automatic logic [31:0] st_model();
    return {25'h0, slave_fsm_busy, master_fsm_busy, rx_fifo_count == 4'h8, rx_fifo_count != 4'h0,
      tx_fifo_count == 4'h0, tx_fifo_count != 4'h8, master_fsm_busy | slave_fsm_busy | bus_other_busy};
  endfunction

  // Counts clock-line edges and hold-timer pulses, and cuts a hang short.
  always @(scl_line) if (presetn) edges++;
  always @(posedge pclk) begin
    cyc++;
    if (data_hold_done === 1'b1) pulses++;
    if (cyc == 6000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    seed = 32'h54f5;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(I2CSAR_OFS_ENABLE, 32'h0, "enable reset");
    rd(I2CSAR_OFS_STATUS, 32'h6, "status reset");
    rd(I2CSAR_OFS_TXLVL, 32'h0, "tx level reset");
    rd(I2CSAR_OFS_HOLD, 32'h1, "hold reset");
    rd(I2CSAR_OFS_ABRT, 32'h0, "cause reset");
    rd(I2CSAR_OFS_CLR_GCALL, 32'h0, "gcall clear read");
    check("gcall clear strobe", gc_q, 1);
    rd(8'h84, 32'h0, "unmapped read");
    check("unmapped error", err_q, 1);
    $display("test reset values done");
    apb(I2CSAR_OFS_ENABLE, 1'b1, 32'hFFFF_FFFD);
    check("enable pin", controller_enable, 1);
    rd(I2CSAR_OFS_ENABLE, 32'h1, "enable on");
    v = $random(seed);
    apb(I2CSAR_OFS_HOLD, 1'b1, v);
    rd(I2CSAR_OFS_HOLD, {16'h0, v[15:0]}, "hold value");
    for (int i = 0; i < 14; i++) begin
      v = $random(seed);
      {master_fsm_busy, slave_fsm_busy, bus_other_busy} <= v[2:0];
      tx_fifo_count <= 4'((i < 2) ? i * 8 : $unsigned($random(seed)) % 9);
      rx_fifo_count <= 4'((i < 2) ? 8 - i * 8 : $unsigned($random(seed)) % 9);
      repeat (2) @(posedge pclk);
      rd(I2CSAR_OFS_STATUS, st_model(), "status");
      rd(I2CSAR_OFS_TXLVL, {28'h0, tx_fifo_count}, "tx level");
      rd(I2CSAR_OFS_RXLVL, {28'h0, rx_fifo_count}, "rx level");
    end
    {master_fsm_busy, slave_fsm_busy, bus_other_busy} <= 3'h0;
    $display("test status and levels done");
    for (int i = 0; i < 17; i++) begin
      tx_fifo_count <= 4'(1 + $unsigned($random(seed)) % 8);
      master_mode <= (i != 11);
      if (i == 16) begin
        apb(I2CSAR_OFS_ENABLE, 1'b1, 32'h3);
        rd(I2CSAR_OFS_ENABLE, 32'h3, "abort busy");
        check("abort pin busy", abort_request, 1);
      end
      repeat (3) @(posedge pclk);
      ev <= 17'h1 << i;
      @(posedge pclk);
      check("abort irq", transmit_abort_irq, 1);
      ev <= 17'h0;
      m_cause = (1 << i) | ((i == 14) ? (1 << 12) : 0);
      repeat (4) @(posedge pclk);
      rd(I2CSAR_OFS_ABRT, {4'h0, tx_fifo_count, 7'h0, 17'(m_cause)}, "cause");
      if (i == 16) begin
        rd(I2CSAR_OFS_ENABLE, 32'h1, "abort done");
        check("abort pin done", abort_request, 0);
      end
      rd((i % 2) ? I2CSAR_OFS_CLR_ABRT : I2CSAR_OFS_CLR_ALL, 32'h0, "clear read");
      check("clear strobe", tc_q, 1);
      rd(I2CSAR_OFS_ABRT, 32'h0, "cause cleared");
    end
    // Gated causes pulsed with their conditions closed must set nothing.
    {repeated_start_allow, slave_read_active, cmd_bits} <= 4'h8;
    tx_fifo_count <= 4'h0;
    master_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    ev <= 17'h0AF20;
    @(posedge pclk);
    check("gated irq", transmit_abort_irq, 0);
    ev <= 17'h0;
    repeat (2) @(posedge pclk);
    rd(I2CSAR_OFS_ABRT, 32'h0, "gated causes");
    $display("test abort causes done");
    apb(I2CSAR_OFS_HOLD, 1'b1, 32'h3);
    edges = 0;
    pulses = 0;
    frame_go <= 1'b1;
    repeat (200) @(posedge pclk);
    frame_go <= 1'b0;
    repeat (60) @(posedge pclk);
    check("hold count", {16'h0, data_hold_count}, 32'h3);
    check("hold pulses", 32'(pulses), 32'(edges));
    $display("test data hold done");
    give_verdict();
  end
endmodule
